/* File: include/adc_pkg.sv */
// Summary of operation
// - full-scale sense input gives code all ones when full scale exceeds zero scale
// - zero-scale sense input gives code all zeros
// - first conversion after power-up uses first_input
// - each later conversion alternates the input
// - word bit 22 flags second_input result
// - only serial clock and data pins
// - sleep after conversion until serial clock activity
// - serial clock low at wake selects external
package adc_pkg;
   // ==========================================================
   // word layout
   localparam int CODE_W = 20;
   localparam int WORD_W = 24;
   localparam int EOC_BIT = 23;
   localparam int CHAN_BIT = 22;
   localparam int SIGN_BIT = 21;
   localparam int OVER_BIT = 20;
   localparam logic [4:0] BIT_LAST = 5'h17;
   localparam logic [CODE_W-1:0] CODE_FULL = 20'hF_FFFF;
   localparam logic [CODE_W-1:0] CODE_ZERO = 20'h0_0000;
   localparam logic CHAN_FIRST = 1'b0;
   // ==========================================================
   // sizes and timing
   localparam int SAMPLE_W = 24;
   localparam int FIFO_DEPTH = 8;
   localparam int SCK_HALF_CYCLES = 4;
   localparam int DIV_W = 8;
   localparam logic [1:0] SYNC_SETTLE = 2'h3;
   // ==========================================================
   // state encodings, gray along the usual path
   typedef enum logic [1:0] {
      CONV_IDLE = 2'b00,
      CONV_SAMPLE = 2'b01,
      CONV_SCALE = 2'b11,
      CONV_PUSH = 2'b10
   } conv_state_t;
   typedef enum logic [1:0] {
      SER_WAKE = 2'b00,
      SER_EMPTY = 2'b01,
      SER_SHIFT = 2'b11
   } ser_state_t;
endpackage : adc_pkg

/* File: rtl/sample_fifo.sv */
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = adc_pkg::WORD_W,
   parameter int DEPTH = adc_pkg::FIFO_DEPTH
) (
   // clock and control
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   import adc_pkg::*;
   localparam int AW = $clog2(DEPTH);
   // ==========================================================
   // storage and pointers
   logic [WIDTH-1:0] mem_q [DEPTH]; // word store
   logic [AW-1:0] wr_q; // write pointer
   logic [AW-1:0] rd_q; // read pointer
   logic [AW:0] count_q; // words held
   logic push; // accepted write
   logic pop; // accepted read

   assign in_ready = count_q != (AW+1)'(DEPTH);
   assign out_valid = count_q != '0;
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // store accepted words
   always_ff @(posedge clock)
   begin
      if (clk_en && push)
      begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
      end
      else if (clk_en)
      begin
         if (push)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop)
         begin
            count_q <= count_q + 1'b1;
         end
         else if (pop && !push)
         begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule : sample_fifo

/* File: rtl/code_scaler.sv */
`timescale 1ns/1ps
module code_scaler #(
   parameter int SAMPLE_W = adc_pkg::SAMPLE_W
) (
   // clock and control
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // request
   input wire logic start,
   input wire logic signed [SAMPLE_W-1:0] vin,
   input wire logic signed [SAMPLE_W-1:0] zs,
   input wire logic signed [SAMPLE_W-1:0] fs,
   // answer
   output logic done,
   output logic [adc_pkg::CODE_W-1:0] code,
   output logic under,
   output logic over
);
   import adc_pkg::*;
   localparam int DW = SAMPLE_W + 1;
   localparam int PW = DW + CODE_W;
   localparam int CW = $clog2(PW + 1);
   // ==========================================================
   // datapath
   logic signed [DW-1:0] diff; // input above zero scale
   logic signed [DW-1:0] span; // full minus zero scale
   logic [DW-1:0] den_q; // divisor
   logic [PW-1:0] dvd_q; // dividend, then quotient
   logic [DW-1:0] rem_q; // partial remainder
   logic [DW:0] r2; // trial remainder
   logic [CW-1:0] cnt_q; // steps left
   logic busy_q; // dividing
   logic done_q; // result pulse
   logic [CODE_W-1:0] code_q; // result code
   logic under_q; // below zero scale
   logic over_q; // above full scale
   logic at_full_q; // input equals full scale
   logic at_zero_q; // input equals zero scale

   assign diff = {vin[SAMPLE_W-1], vin} - {zs[SAMPLE_W-1], zs};
   assign span = {fs[SAMPLE_W-1], fs} - {zs[SAMPLE_W-1], zs};
   assign r2 = {rem_q, dvd_q[PW-1]};
   assign done = done_q;
   assign code = code_q;
   assign under = under_q;
   assign over = over_q;

   // code = (vin - zs) * full / (fs - zs), clamped at both ends
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         code_q <= CODE_ZERO;
         den_q <= '0;
         dvd_q <= '0;
         rem_q <= '0;
         cnt_q <= '0;
         under_q <= 1'b0;
         over_q <= 1'b0;
         at_full_q <= 1'b0;
         at_zero_q <= 1'b0;
      end
      else if (clk_en)
      begin
         done_q <= 1'b0;
         if (start && !busy_q)
         begin
            under_q <= diff < 0;
            over_q <= diff > span;
            at_full_q <= diff == span;
            at_zero_q <= diff == 0;
            if (diff <= 0)
            begin
               // zero scale and below give all zeros
               code_q <= CODE_ZERO;
               done_q <= 1'b1;
            end
            else if (diff >= span)
            begin
               // full scale and above give all ones
               code_q <= CODE_FULL;
               done_q <= 1'b1;
            end
            else
            begin
               // restoring divide, one quotient bit a cycle
               dvd_q <= PW'(diff) * PW'(CODE_FULL);
               den_q <= span;
               rem_q <= '0;
               cnt_q <= CW'(PW);
               busy_q <= 1'b1;
            end
         end
         else if (busy_q)
         begin
            if (cnt_q == '0)
            begin
               code_q <= dvd_q[CODE_W-1:0];
               done_q <= 1'b1;
               busy_q <= 1'b0;
            end
            else
            begin
               cnt_q <= cnt_q - 1'b1;
               if (r2 >= {1'b0, den_q})
               begin
                  rem_q <= DW'(r2 - {1'b0, den_q});
                  dvd_q <= {dvd_q[PW-2:0], 1'b1};
               end
               else
               begin
                  rem_q <= r2[DW-1:0];
                  dvd_q <= {dvd_q[PW-2:0], 1'b0};
               end
            end
         end
      end
   end

   // ==========================================================
   // checks
   a_full_code: assert property (@(posedge clock) disable iff (rst)
      done_q && at_full_q && !at_zero_q |-> code_q == CODE_FULL && !over_q)
      else $error("full scale input did not give all ones");
   a_zero_code: assert property (@(posedge clock) disable iff (rst)
      done_q && at_zero_q |-> code_q == CODE_ZERO && !under_q)
      else $error("zero scale input did not give all zeros");
endmodule : code_scaler

/* File: rtl/alternating_channel_adc_output.sv */
`timescale 1ns/1ps
module alternating_channel_adc_output #(
   parameter int SCK_DIV = adc_pkg::SCK_HALF_CYCLES
) (
   // clock and control
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // serial link pins
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   output logic sdo,
   // converter front end
   output logic conv_start,
   output logic conv_channel,
   input wire logic conv_ready,
   input wire logic signed [adc_pkg::SAMPLE_W-1:0] sample_value,
   input wire logic signed [adc_pkg::SAMPLE_W-1:0] zero_scale_sense,
   input wire logic signed [adc_pkg::SAMPLE_W-1:0] full_scale_sense
);
   import adc_pkg::*;
   // ==========================================================
   // declarations
   logic sck_meta_q; // first sync stage
   logic sck_sync_q; // second sync stage
   logic sck_prev_q; // last clock level
   logic sck_lvl; // active serial clock level
   logic sck_rise; // serial clock rising
   logic sck_fall; // serial clock falling
   logic ext_mode_q; // host supplies the clock
   logic [1:0] settle_q; // wake delay
   logic mode_pick; // mode sampled this cycle
   logic first_rise; // first activity of a frame
   ser_state_t ser_q; // output state
   conv_state_t conv_q; // conversion state
   logic go_q; // conversion allowed
   logic chan_q; // input in use
   logic start_q; // conversion start pulse
   logic [WORD_W-1:0] result_q; // assembled word
   logic [WORD_W-1:0] word_q; // shift register
   logic [4:0] bit_cnt_q; // bits sent
   logic sdo_q; // data pin
   logic sck_out_q; // own clock
   logic sck_oe_q; // own clock drive
   logic [DIV_W-1:0] div_q; // clock divider
   logic scale_start; // scaler request
   logic scale_done; // scaler answer
   logic [CODE_W-1:0] scale_code; // scaled result
   logic scale_under; // below zero scale
   logic scale_over; // above full scale
   logic fifo_in_ready; // buffer has room
   logic fifo_out_valid; // buffer has a word
   logic fifo_out_ready; // output takes a word
   logic [WORD_W-1:0] fifo_out_data; // oldest word
   logic started_q; // a conversion was issued
   logic last_chan_q; // input of last start

   assign sck_out = sck_out_q;
   assign sck_oe = sck_oe_q;
   assign sdo = sdo_q;
   assign conv_start = start_q;
   assign conv_channel = chan_q;

   // ==========================================================
   // serial clock sampling
   // the pin is foreign, so two stages before any use
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sck_meta_q <= 1'b0;
         sck_sync_q <= 1'b0;
         sck_prev_q <= 1'b0;
      end
      else if (clk_en)
      begin
         sck_meta_q <= sck_in;
         sck_sync_q <= sck_meta_q;
         sck_prev_q <= sck_lvl;
      end
   end

   // edges come from the pin or from our own divider
   assign sck_lvl = ext_mode_q ? sck_sync_q : sck_out_q;
   assign sck_rise = sck_lvl && !sck_prev_q;
   assign sck_fall = !sck_lvl && sck_prev_q;
   assign mode_pick = (ser_q == SER_WAKE) && (settle_q == SYNC_SETTLE);
   assign first_rise = (ser_q == SER_SHIFT) && sck_rise && (bit_cnt_q == '0);

   // ==========================================================
   // wake, mode choice and output shifting
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         ser_q <= SER_WAKE;
         settle_q <= '0;
         ext_mode_q <= 1'b1;
         sck_oe_q <= 1'b0;
         word_q <= '0;
         bit_cnt_q <= '0;
         sdo_q <= 1'b1;
      end
      else if (clk_en)
      begin
         case (ser_q)
            SER_WAKE:
            begin
               // let the sync stages fill, then read the clock line
               if (mode_pick)
               begin
                  ext_mode_q <= !sck_sync_q;
                  sck_oe_q <= sck_sync_q;
                  ser_q <= SER_EMPTY;
               end
               else
               begin
                  settle_q <= settle_q + 1'b1;
               end
            end
            SER_EMPTY:
            begin
               // busy shows as a high data pin
               sdo_q <= 1'b1;
               if (fifo_out_valid)
               begin
                  word_q <= fifo_out_data;
                  sdo_q <= fifo_out_data[EOC_BIT];
                  bit_cnt_q <= '0;
                  ser_q <= SER_SHIFT;
               end
            end
            SER_SHIFT:
            begin
               // next bit on each falling edge, msb first
               if (sck_fall)
               begin
                  word_q <= {word_q[WORD_W-2:0], 1'b0};
                  sdo_q <= word_q[WORD_W-2];
                  if (bit_cnt_q == BIT_LAST)
                  begin
                     sdo_q <= 1'b1;
                     ser_q <= SER_EMPTY;
                  end
                  else
                  begin
                     bit_cnt_q <= bit_cnt_q + 1'b1;
                  end
               end
            end
            default:
            begin
               ser_q <= SER_WAKE;
            end
         endcase
      end
   end

   // ==========================================================
   // own serial clock, only while a word is out
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sck_out_q <= 1'b0;
         div_q <= '0;
      end
      else if (clk_en)
      begin
         if (sck_oe_q && (ser_q == SER_SHIFT))
         begin
            if (div_q == DIV_W'(SCK_DIV - 1))
            begin
               div_q <= '0;
               sck_out_q <= !sck_out_q;
            end
            else
            begin
               div_q <= div_q + 1'b1;
            end
         end
         else
         begin
            // park low between words
            div_q <= '0;
            sck_out_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // conversion permission
   // set by the wake and by clock activity; set beats clear
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         go_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (mode_pick || first_rise)
         begin
            go_q <= 1'b1;
         end
         else if (conv_q == CONV_IDLE)
         begin
            go_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // conversion sequencing
   assign scale_start = (conv_q == CONV_SAMPLE) && conv_ready;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         conv_q <= CONV_IDLE;
         chan_q <= CHAN_FIRST;
         start_q <= 1'b0;
         result_q <= '0;
      end
      else if (clk_en)
      begin
         start_q <= 1'b0;
         case (conv_q)
            CONV_IDLE:
            begin
               // asleep until allowed
               if (go_q)
               begin
                  start_q <= 1'b1;
                  conv_q <= CONV_SAMPLE;
               end
            end
            CONV_SAMPLE:
            begin
               if (conv_ready)
               begin
                  conv_q <= CONV_SCALE;
               end
            end
            CONV_SCALE:
            begin
               // status nibble: ready, input, positive, over range
               if (scale_done)
               begin
                  result_q <= {1'b0, chan_q, !scale_under, scale_over, scale_code};
                  conv_q <= CONV_PUSH;
               end
            end
            CONV_PUSH:
            begin
               // waits here while the buffer is full
               if (fifo_in_ready)
               begin
                  chan_q <= !chan_q;
                  conv_q <= CONV_IDLE;
               end
            end
            default:
            begin
               conv_q <= CONV_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // scaling and buffering
   code_scaler #(
      .SAMPLE_W(SAMPLE_W)
   ) u_scaler (
      .clock(clock),
      .rst(rst),
      .clk_en(clk_en),
      .start(scale_start),
      .vin(sample_value),
      .zs(zero_scale_sense),
      .fs(full_scale_sense),
      .done(scale_done),
      .code(scale_code),
      .under(scale_under),
      .over(scale_over)
   );

   assign fifo_out_ready = (ser_q == SER_EMPTY);

   sample_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst(rst),
      .clk_en(clk_en),
      .in_valid(conv_q == CONV_PUSH),
      .in_ready(fifo_in_ready),
      .in_data(result_q),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // ==========================================================
   // checks
   // history of issued conversions
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         started_q <= 1'b0;
         last_chan_q <= CHAN_FIRST;
      end
      else if (clk_en && start_q)
      begin
         started_q <= 1'b1;
         last_chan_q <= chan_q;
      end
   end

   a_first_input: assert property (@(posedge clock) disable iff (rst)
      start_q && !started_q |-> chan_q == CHAN_FIRST)
      else $error("first conversion not on first input");
   a_strict_alternation: assert property (@(posedge clock) disable iff (rst)
      start_q && started_q |-> chan_q != last_chan_q)
      else $error("conversion input did not alternate");
   a_channel_bit: assert property (@(posedge clock) disable iff (rst || !clk_en)
      ser_q == SER_EMPTY && fifo_out_valid |=> word_q[CHAN_BIT] == $past(fifo_out_data[CHAN_BIT]))
      else $error("channel flag lost on load");
   a_no_clock_drive: assert property (@(posedge clock) disable iff (rst)
      ext_mode_q |-> !sck_oe_q && !sck_out_q)
      else $error("clock driven in external mode");
   a_sleep_hold: assert property (@(posedge clock) disable iff (rst || !clk_en)
      conv_q == CONV_IDLE && !go_q && !mode_pick && !first_rise |=> !start_q [*2])
      else $error("conversion started without clock activity");
   a_wake_on_clock: assert property (@(posedge clock) disable iff (rst || !clk_en)
      first_rise && conv_q == CONV_IDLE |-> ##[1:3] start_q)
      else $error("clock activity did not start conversion");
   a_mode_pick: assert property (@(posedge clock) disable iff (rst || !clk_en)
      mode_pick |=> ext_mode_q == !$past(sck_sync_q) && ser_q == SER_EMPTY)
      else $error("clock mode not taken from wake level");
   a_ready_msb: assert property (@(posedge clock) disable iff (rst)
      ser_q == SER_SHIFT && bit_cnt_q == '0 && !sck_prev_q |-> !sdo_q)
      else $error("ready bit not low at word start");
endmodule : alternating_channel_adc_output

/* File: test/host_model.sv */
`timescale 1ns/1ps
module host_model (
   // mode and trigger
   input wire logic rst,
   input wire logic ext,
   input wire logic go,
   // link wires
   output logic sck_drv,
   input wire logic sck_wire,
   input wire logic sdo,
   // captured result
   output logic [23:0] word,
   output logic [23:0] diff,
   output int nwords
);
   logic pulse = 1'b0; // own clock, parks low between frames
   logic [23:0] shreg = 24'h00_0000; // incoming bits
   int nbits = 0; // bits taken in this word
   initial nwords = 0;
   initial word = 24'h00_0000; // no word taken yet, so the first difference is defined
   // ==========================================
   // link clock: pulses in external mode, pull-up level otherwise
   assign sck_drv = ext ? pulse : 1'b1;
   // one frame of 24 clock pulses, 80 ns period
   always @(posedge go)
   begin
      repeat (24)
      begin
         #40 pulse = 1'b1;
         #40 pulse = 1'b0;
      end
   end
   // drop any partial word at reset release
   always @(negedge rst)
   begin
      nbits = 0;
   end
   // ==========================================
   // capture: data out taken on each rising clock, msb first
   always @(posedge sck_wire)
   begin
      shreg = {shreg[22:0], sdo};
      nbits++;
      if (nbits == 24)
      begin
         diff = shreg - word;
         word = shreg;
         nwords++;
         nbits = 0;
      end
   end
endmodule : host_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
   import adc_pkg::*;
   // ==========================================
   // signals
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic sck_in, sck_out, sck_oe, sdo; // link wires
   logic conv_start, conv_channel; // front end request
   logic conv_ready = 1'b0; // front end answer
   logic signed [23:0] vin = 24'h00_0000;
   logic signed [23:0] zs = 24'h00_0000;
   logic signed [23:0] fs = 24'h10_0000;
   logic ext = 1'b1; // host clock mode
   logic go = 1'b0; // frame trigger
   logic sck_drv;
   logic [23:0] word, diff;
   int nwords;
   int nconv; // conversions started since reset
   int error_cnt = 0;
   int checks = 0;
   logic [31:0] seed = 32'h0000_0029; // xorshift state
   logic [23:0] exp_q[$]; // expected words in order
   // ==========================================
   // clock and wire level
   always #2 clock = ~clock;
   assign sck_in = sck_oe ? sck_out : sck_drv;
   // ==========================================
   // instances
   alternating_channel_adc_output #(.SCK_DIV(4)) dut_u (
      .clock(clock), .rst(rst), .clk_en(1'b1),
      .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .sdo(sdo),
      .conv_start(conv_start), .conv_channel(conv_channel), .conv_ready(conv_ready),
      .sample_value(vin), .zero_scale_sense(zs), .full_scale_sense(fs));
   host_model host_u (
      .rst(rst), .ext(ext), .go(go), .sck_drv(sck_drv), .sck_wire(sck_in),
      .sdo(sdo), .word(word), .diff(diff), .nwords(nwords));
   // ==========================================
   // random source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // reference word for one conversion
   function automatic logic [23:0] ref_word(input logic ch);
      longint d, sp, c;
      d = longint'(vin) - longint'(zs);
      sp = longint'(fs) - longint'(zs);
      if (d < 0)
         c = 0;
      else if (d > sp)
         c = 64'h0000_0000_000F_FFFF;
      else
         c = d * 64'h0000_0000_000F_FFFF / sp;
      return {1'b0, ch, vin >= zs, vin > fs, c[19:0]};
   endfunction : ref_word
   // ==========================================
   // front end model: answers each start with a sample
   always @(posedge clock)
   begin
      logic [31:0] r1, r2, r3;
      longint lz, ls;
      if (conv_start === 1'b1 && rst === 1'b0)
      begin
         #1 `CHK(conv_channel, nconv[0])
         r1 = rnd();
         repeat (1 + r1[1:0]) @(negedge clock);
         r2 = rnd();
         r3 = rnd();
         zs = {4'h0, r1[19:0]};
         fs = zs + ({2'h0, r2[21:0]} | 24'h01_0000);
         lz = zs;
         ls = fs - zs;
         case (nconv)
            0: vin = zs;
            1: vin = fs;
            2: vin = zs - 24'h00_0001;
            3: vin = fs + 24'h00_0001;
            default: vin = 24'(lz - ls / 8 + (r3 % (ls + ls / 4)));
         endcase
         exp_q.push_back(ref_word(nconv[0]));
         conv_ready = 1'b1;
         nconv++;
         @(negedge clock);
         conv_ready = 1'b0;
      end
   end
   // ==========================================
   // closing report
   task print_verdict;
      if (error_cnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   // a wait that ran out
   task timed_out;
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 0, 1);
      print_verdict;
   endtask : timed_out
   // reset with the host holding the chosen clock level
   task do_reset(input logic mode);
      rst = 1'b1;
      ext = mode;
      repeat (6) @(negedge clock);
      nconv = 0;
      exp_q.delete();
      rst = 1'b0;
   endtask : do_reset
   // read n words and compare each with the reference
   task run_frames(input int n);
      int prev;
      logic [23:0] e, last; // expected word, and the one before it
      last = word;
      for (int i = 0; i < n; i++)
      begin
         prev = nwords;
         if (ext)
         begin
            for (int k = 0; k < 600 && sdo !== 1'b0; k++) @(negedge clock);
            if (sdo !== 1'b0) timed_out;
            go = 1'b1;
            @(negedge clock);
            go = 1'b0;
         end
         for (int k = 0; k < 1000 && nwords == prev; k++) @(negedge clock);
         if (nwords == prev) timed_out;
         e = exp_q.size() ? exp_q.pop_front() : 24'hxx_xxxx;
         `CHK(word, e)
         `CHK(diff, e - last)
         last = e;
         `CHK(word[CHAN_BIT], i[0])
         if (ext)
         begin
            // no clock, no further conversion: the device sleeps
            repeat (200) @(negedge clock);
            `CHK(nconv, i + 2)
         end
      end
   endtask : run_frames
   // ==========================================
   // main sequence
   initial
   begin
      nconv = 0;
      do_reset(1'b1);
      repeat (10) @(negedge clock);
      `CHK(sck_oe, 1'b0)
      for (int k = 0; k < 600 && sdo !== 1'b0; k++) @(negedge clock);
      if (sdo !== 1'b0) timed_out;
      `CHK(nconv, 1)
      run_frames(10);
      // second reset in mid-run, clock line high selects own clock
      do_reset(1'b0);
      repeat (10) @(negedge clock);
      `CHK(sck_oe, 1'b1)
      run_frames(6);
      print_verdict;
   end
endmodule : tb_top
